/* File: core/xmi_pin_if.sv */
// Purpose: memory side pin interface with parity and configuration registers
// Assumes: rst synchronous active high; read data captured on sys_clk
// Notes:   one access at a time; request port is a valid/ready pair
`timescale 1ns/10ps
module xmi_pin_if #(
  parameter int unsigned DW = 32,
  parameter int unsigned NBANK = 4,
  parameter logic [1:0]  PARITY = 2'h0,
  parameter bit          IO_REG = 1'b0,
  parameter bit          USE_BOOT = 1'b0,
  parameter int unsigned ACC_CYC = xmi_pkg::ACCESS_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // request port
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [1:0]        req_bank,
  input  wire logic [31:0]       req_addr,
  input  wire logic [DW-1:0]     req_wdata,
  input  wire logic [DW/8-1:0]   req_be,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic                   rsp_err,
  output logic [DW-1:0]          rsp_rdata,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // memory pins
  input  wire logic [DW-1:0]     mem_dq_i,
  output logic [DW-1:0]          mem_dq_o,
  output logic [DW-1:0]          mem_dq_t,
  input  wire logic [DW/8-1:0]   mem_par_i,
  output logic [DW/8-1:0]        mem_par_o,
  output logic [DW/8-1:0]        mem_par_t,
  output logic [31:0]            mem_addr,
  output logic                   mem_rst_pd_n,
  output logic [NBANK-1:0]       mem_cen_n,
  output logic [NBANK-1:0]       mem_ce,
  output logic [NBANK-1:0]       mem_oen_n,
  output logic                   mem_wen_n,
  output logic [DW/8-1:0]        mem_qwen_n,
  output logic [DW/8-1:0]        mem_ben,
  output logic                   mem_adv_ld_n,
  output logic                   mem_burst_order,
  output logic                   mem_rnw,
  output logic                   mem_cken,
  output logic                   mem_cfg_entry,
  output logic                   mem_clk,
  // boot primitive side
  output logic                   boot_clk,
  input  wire logic [3:0]        boot_dq_i,
  output logic [3:0]             boot_dq_o,
  output logic [3:0]             boot_dq_t
);

  localparam int unsigned NB = DW / 8;

  xmi_pkg::xmi_state_e state;
  xmi_pkg::xmi_state_e next_state;

  logic                 cur_write;
  logic [1:0]           cur_bank;
  logic [31:0]          cur_addr;
  logic [7:0]           cnt;
  logic                 cnt_last;
  logic [DW-1:0]        rd_q1;
  logic [DW-1:0]        rd_q2;
  logic [NB-1:0]        par_q1;
  logic [NB-1:0]        par_q2;
  logic [DW-1:0]        cap_data;
  logic [NB-1:0]        cap_par;
  logic [NB-1:0]        calc_par_rd;
  logic [NB-1:0]        calc_par_wr;
  logic                 par_err;
  logic                 mclk;
  logic                 next_mclk;
  logic                 taken;
  logic [NBANK-1:0]     bank_hot;
  logic                 active;
  xmi_pkg::xmi_cfg_s    cfg [NBANK];
  logic [31:0]          fail_addr [NBANK];
  xmi_pkg::xmi_cfg_s    cur_cfg;
  logic                 sync_mode;
  logic [1:0]           sel_bank;
  logic                 sel_write;

  assign taken = req_valid && req_ready;
  assign cnt_last = (cnt == 8'h00);
  // taking cycle must already see the new request, not the previous one
  assign sel_bank = taken ? req_bank : cur_bank;
  assign sel_write = taken ? req_write : cur_write;
  assign cur_cfg = cfg[sel_bank];
  // page and burst modes run the memory clock and the address strobe
  assign sync_mode = cur_cfg.rd_burst || (cur_cfg.op_mode != xmi_pkg::OPM_ASYNC);

  function automatic logic [NB-1:0] byte_par(input logic [DW-1:0] d);
    logic [NB-1:0] p;
    p = '0;
    for (int i = 0; i < int'(NB); i++) begin
      p[i] = (^d[i*8 +: 8]) ^ (PARITY == xmi_pkg::PAR_ODD);
    end
    return p;
  endfunction : byte_par

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      xmi_pkg::ST_IDLE:   if (taken) next_state = xmi_pkg::ST_SETUP;
      xmi_pkg::ST_SETUP:  next_state = xmi_pkg::ST_ACCESS;
      xmi_pkg::ST_ACCESS: if (cnt_last) next_state = cur_write ? xmi_pkg::ST_DONE : xmi_pkg::ST_CAPT;
      xmi_pkg::ST_CAPT:   if (cnt_last) next_state = xmi_pkg::ST_DONE;
      xmi_pkg::ST_DONE:   next_state = xmi_pkg::ST_IDLE;
      default:            next_state = xmi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= xmi_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= 8'h00;
    end else if (next_state == xmi_pkg::ST_ACCESS && state != xmi_pkg::ST_ACCESS) begin
      cnt <= 8'(ACC_CYC - 1);
    end else if (next_state == xmi_pkg::ST_CAPT && state != xmi_pkg::ST_CAPT) begin
      cnt <= IO_REG ? 8'h01 : 8'h00;
    end else if (!cnt_last) begin
      cnt <= cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_write <= 1'b0;
      cur_bank <= 2'h0;
      cur_addr <= 32'h0000_0000;
    end else if (taken) begin
      cur_write <= req_write;
      cur_bank <= req_bank;
      cur_addr <= req_addr;
    end
  end

  // input register stages; capture clock is sys_clk itself
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_q1 <= '0;
      rd_q2 <= '0;
      par_q1 <= '0;
      par_q2 <= '0;
    end else begin
      rd_q1 <= mem_dq_i;
      if (USE_BOOT) begin
        rd_q1[3:0] <= boot_dq_i;
      end
      rd_q2 <= rd_q1;
      par_q1 <= mem_par_i;
      par_q2 <= par_q1;
    end
  end

  assign cap_data = IO_REG ? rd_q2 : rd_q1;
  assign cap_par = IO_REG ? par_q2 : par_q1;
  assign calc_par_rd = byte_par(cap_data);
  assign calc_par_wr = byte_par(req_wdata);
  assign par_err = (PARITY != xmi_pkg::PAR_NONE) && (calc_par_rd != cap_par);

  // handshake and response
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      req_ready <= (next_state == xmi_pkg::ST_IDLE);
      rsp_valid <= (next_state == xmi_pkg::ST_DONE);
      if (state == xmi_pkg::ST_CAPT && cnt_last) begin
        rsp_rdata <= cap_data;
        rsp_err <= par_err;
      end else if (next_state == xmi_pkg::ST_DONE) begin
        rsp_err <= 1'b0;
      end
    end
  end

  // chip, output and write enables
  assign active = (next_state != xmi_pkg::ST_IDLE) && (next_state != xmi_pkg::ST_DONE);
  assign bank_hot = NBANK'(1) << (taken ? req_bank : cur_bank);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_cen_n <= {NBANK{xmi_pkg::RST_CEN_N}};
      mem_ce <= '0;
      mem_oen_n <= {NBANK{xmi_pkg::RST_OEN_N}};
      mem_wen_n <= xmi_pkg::RST_WEN_N;
      mem_qwen_n <= '1;
      mem_ben <= '0;
      mem_rnw <= xmi_pkg::RST_RNW;
    end else begin
      mem_cen_n <= active ? ~bank_hot : '1;
      mem_ce <= active ? bank_hot : '0;
      mem_oen_n <= (active && !(taken ? req_write : cur_write)) ? ~bank_hot : '1;
      mem_wen_n <= !(next_state == xmi_pkg::ST_ACCESS && cur_write);
      mem_qwen_n <= (next_state == xmi_pkg::ST_ACCESS && cur_write) ? ~mem_ben : '1;
      if (taken) begin
        mem_ben <= req_be;
        mem_rnw <= !req_write;
      end else if (!active) begin
        mem_ben <= '0;
        mem_rnw <= xmi_pkg::RST_RNW;
      end
    end
  end

  // address, data and turnaround
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_addr <= 32'h0000_0000;
      mem_dq_o <= '0;
      mem_dq_t <= '0;
      mem_par_o <= '0;
      mem_par_t <= '0;
    end else if (taken) begin
      mem_addr <= req_addr;
      mem_dq_o <= req_write ? req_wdata : '0;
      mem_dq_t <= req_write ? '0 : '1;
      mem_par_o <= (req_write && PARITY != xmi_pkg::PAR_NONE) ? calc_par_wr : '0;
      mem_par_t <= (req_write || PARITY == xmi_pkg::PAR_NONE) ? '0 : '1;
      if (USE_BOOT) begin
        mem_dq_o[3:0] <= 4'h0;
        mem_dq_t[3:0] <= 4'hf;
      end
    end else if (next_state == xmi_pkg::ST_IDLE) begin
      mem_dq_t <= '0;
      mem_par_t <= '0;
    end
  end

  // burst control, clock and configuration entry
  assign next_mclk = (next_state == xmi_pkg::ST_ACCESS || next_state == xmi_pkg::ST_CAPT) && sync_mode && !mclk;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_adv_ld_n <= xmi_pkg::RST_ADV_LD_N;
      mem_burst_order <= xmi_pkg::RST_BURST_ORDER;
      mem_cken <= 1'b0;
      mem_cfg_entry <= 1'b0;
      mem_rst_pd_n <= xmi_pkg::RST_RPN;
      mclk <= 1'b0;
      mem_clk <= 1'b0;
      boot_clk <= 1'b0;
    end else begin
      mem_adv_ld_n <= !(next_state == xmi_pkg::ST_SETUP && sync_mode);
      mem_burst_order <= xmi_pkg::RST_BURST_ORDER;
      mem_cken <= active && sync_mode;
      // only configuration writes raise the entry pin
      mem_cfg_entry <= active && sel_write && (cur_cfg.cre_drive || cur_cfg.cre);
      mem_rst_pd_n <= xmi_pkg::RST_RPN;
      mclk <= next_mclk;
      mem_clk <= USE_BOOT ? 1'b0 : next_mclk;
      boot_clk <= USE_BOOT ? next_mclk : 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_dq_o <= 4'h0;
      boot_dq_t <= 4'h0;
    end else if (USE_BOOT && taken) begin
      boot_dq_o <= req_write ? req_wdata[3:0] : 4'h0;
      boot_dq_t <= req_write ? 4'h0 : 4'hf;
    end else if (next_state == xmi_pkg::ST_IDLE) begin
      boot_dq_t <= 4'h0;
    end
  end

  // register groups
  logic        reg_hit;
  logic [1:0]  reg_idx;
  logic        reg_cfg_grp;
  assign reg_idx = reg_addr[3:2];
  assign reg_cfg_grp = reg_addr[4];
  assign reg_hit = (reg_addr[7:5] == 3'h0) && (reg_addr[1:0] == 2'h0) && (32'(reg_idx) < NBANK);

  for (genvar b = 0; b < int'(NBANK); b++) begin : g_bank
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        cfg[b] <= xmi_pkg::ACCESS_CFG_RESET;
        fail_addr[b] <= xmi_pkg::FAIL_ADDR_RESET;
      end else begin
        if (reg_wr && reg_hit && reg_cfg_grp && reg_idx == 2'(b)) begin
          cfg[b].cre <= reg_wdata[31];
          cfg[b].rd_burst <= reg_wdata[30];
          cfg[b].cre_drive <= reg_wdata[6];
          cfg[b].op_mode <= reg_wdata[1:0];
        end
        if (state == xmi_pkg::ST_CAPT && cnt_last && par_err && cur_bank == 2'(b)) begin
          fail_addr[b] <= cur_addr;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= xmi_pkg::UNMAPPED_READ;
    end else if (reg_rd && reg_hit) begin
      reg_rdata <= reg_cfg_grp ? 32'(cfg[reg_idx]) : fail_addr[reg_idx];
    end else begin
      reg_rdata <= xmi_pkg::UNMAPPED_READ;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic rst_d;
  always_ff @(posedge sys_clk) rst_d <= rst;

  property p_reset_enables;
    rst_d |-> (&mem_cen_n) && (mem_ce == '0) && (&mem_oen_n) && mem_wen_n && mem_rnw;
  endproperty
  a_reset_enables: assert property (p_reset_enables) else $error("enables not at rest after reset");

  property p_reset_pins;
    rst_d |-> mem_addr == 32'h0 && mem_rst_pd_n && mem_dq_t == '0 && !mem_cken && !mem_cfg_entry;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins not at reset level");

  property p_write_drives;
    !mem_wen_n |-> !mem_rnw && (&mem_oen_n) && !(&mem_cen_n);
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("write pulse without write setup");

  property p_read_released;
    (mem_oen_n != '1) |-> mem_rnw && mem_wen_n && (mem_dq_t[DW-1:4] == '1);
  endproperty
  a_read_released: assert property (p_read_released) else $error("data bus driven during read");

  property p_cen_ce_pair;
    mem_ce == ~mem_cen_n;
  endproperty
  a_cen_ce_pair: assert property (p_cen_ce_pair) else $error("chip enables disagree");

  property p_read_latency;
    taken && !req_write |-> ##[3:40] rsp_valid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read not answered");

  property p_fail_record;
    rsp_valid && rsp_err |-> fail_addr[cur_bank] == cur_addr && !cur_write;
  endproperty
  a_fail_record: assert property (p_fail_record) else $error("failing address not recorded");

  property p_cfg_entry_write;
    mem_cfg_entry |-> !mem_rnw && !(&mem_cen_n);
  endproperty
  a_cfg_entry_write: assert property (p_cfg_entry_write) else $error("entry pin outside config write");

  property p_order_held;
    mem_burst_order;
  endproperty
  a_order_held: assert property (p_order_held) else $error("burst order left rest level");

  c_write_done: cover property (taken && req_write ##[3:20] rsp_valid);
  c_read_done: cover property (taken && !req_write ##[3:20] rsp_valid && !rsp_err);
  c_parity_fail: cover property (rsp_valid && rsp_err);
  c_cfg_write: cover property (mem_cfg_entry);

endmodule : xmi_pin_if

/* File: core/xmi_pkg.sv */
// Purpose: constants and types of the external memory pin interface
// Assumes: 32-bit register port, word aligned offsets
// Notes:   register offsets are byte addresses
package xmi_pkg;

  // register map
  localparam logic [7:0]  OFF_FAIL_ADDR_0 = 8'h00;
  localparam logic [7:0]  OFF_ACCESS_CFG_0 = 8'h10;
  localparam logic [31:0] FAIL_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] ACCESS_CFG_RESET = 32'h0000_0024;
  localparam logic [3:0]  CFG_FIXED_NIBBLE = 4'h9;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // operating modes of the configuration register
  localparam logic [1:0]  OPM_ASYNC = 2'h0;
  localparam logic [1:0]  OPM_PAGE = 2'h1;
  localparam logic [1:0]  OPM_BURST = 2'h2;

  // parity selection
  localparam logic [1:0]  PAR_NONE = 2'h0;
  localparam logic [1:0]  PAR_ODD = 2'h1;
  localparam logic [1:0]  PAR_EVEN = 2'h2;

  // timing counts in sys_clk cycles
  localparam int unsigned ACCESS_CYCLES = 2;

  // pin levels out of reset
  localparam logic        RST_CEN_N = 1'b1;
  localparam logic        RST_OEN_N = 1'b1;
  localparam logic        RST_WEN_N = 1'b1;
  localparam logic        RST_ADV_LD_N = 1'b1;
  localparam logic        RST_BURST_ORDER = 1'b1;
  localparam logic        RST_RNW = 1'b1;
  localparam logic        RST_RPN = 1'b1;

  typedef struct packed {
    logic        cre;          // bit 31
    logic        rd_burst;     // bit 30
    logic [22:0] rsvd_hi;      // bits 29:7
    logic        cre_drive;    // bit 6
    logic [3:0]  rsvd_fixed;   // bits 5:2
    logic [1:0]  op_mode;      // bits 1:0
  } xmi_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_ACCESS = 3'b010,
    ST_CAPT   = 3'b011,
    ST_DONE   = 3'b100
  } xmi_state_e;

endpackage : xmi_pkg

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for xmi_pin_if
// Assumes: 4 banks, 32-bit data, even parity, no boot path
// Notes:   access counts derived from ACC
`timescale 1ns/10ps
module tb_top;
  localparam int ACC = 3;
  logic        sys_clk, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        corrupt = 1'b0, req_ready, rsp_valid, rsp_err, mem_rst_pd_n, mem_wen_n, mem_adv_ld_n;
  logic        mem_burst_order, mem_rnw, mem_cken, mem_cfg_entry, r_err;
  logic [1:0]  req_bank = 2'h0;
  logic [3:0]  req_be = 4'h0, mem_par_i, mem_par_o, mem_par_t, mem_cen_n, mem_ce, mem_oen_n;
  logic [3:0]  mem_qwen_n, mem_ben, last_ben, last_qwen;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, reg_wdata = 32'h0, rsp_rdata, reg_rdata;
  logic [31:0] mem_dq_i, mem_dq_o, mem_dq_t, mem_addr, rd, r_data;
  int          checks = 0, n_mismatch = 0, wen_cyc = 0, cfg_cyc = 0, cken_cyc = 0, adv_cyc = 0;
  int          bad = 0, r_lat;

  xmi_pin_if #(.DW(32), .NBANK(4), .PARITY(xmi_pkg::PAR_EVEN), .IO_REG(1'b0), .USE_BOOT(1'b0),
    .ACC_CYC(ACC)) i_dut (.sys_clk, .rst, .req_valid, .req_write, .req_bank, .req_addr, .req_wdata,
    .req_be, .req_ready, .rsp_valid, .rsp_err, .rsp_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .mem_dq_i, .mem_dq_o, .mem_dq_t, .mem_par_i, .mem_par_o, .mem_par_t, .mem_addr,
    .mem_rst_pd_n, .mem_cen_n, .mem_ce, .mem_oen_n, .mem_wen_n, .mem_qwen_n, .mem_ben, .mem_adv_ld_n,
    .mem_burst_order, .mem_rnw, .mem_cken, .mem_cfg_entry, .mem_clk(), .boot_clk(), .boot_dq_i(4'h0),
    .boot_dq_o(), .boot_dq_t());

  xmi_mem_model i_mem (.sys_clk, .cen_n(mem_cen_n), .oen_n(mem_oen_n), .wen_n(mem_wen_n),
    .qwen_n(mem_qwen_n), .addr(mem_addr), .dq_o(mem_dq_o), .par_o(mem_par_o), .corrupt,
    .dq_i(mem_dq_i), .par_i(mem_par_i));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // pin monitor: counts strobe cycles and illegal combinations
  always @(posedge sys_clk) begin
    if (!rst) begin
      if (mem_wen_n === 1'b0) begin
        wen_cyc++;
        last_ben = mem_ben;
        last_qwen = mem_qwen_n;
        if (mem_dq_t !== 32'h0 || mem_rnw !== 1'b0) bad++;
      end
      if (mem_oen_n !== 4'hf && mem_dq_t !== 32'hffff_ffff) bad++;
      if (mem_ce !== ~mem_cen_n) bad++;
      if (mem_cfg_entry === 1'b1) cfg_cyc++;
      if (mem_cken === 1'b1) cken_cyc++;
      if (mem_adv_ld_n === 1'b0) adv_cyc++;
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    rd = reg_rdata;
  endtask : reg_read

  task automatic mem_acc(input logic wr, input logic [1:0] bk, input logic [31:0] a, input logic [31:0] d,
                         input logic [3:0] be);
    int n;
    req_valid <= 1'b1;
    req_write <= wr;
    req_bank <= bk;
    req_addr <= a;
    req_wdata <= d;
    req_be <= be;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (req_ready !== 1'b1 && n < 50);
    if (req_ready !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: request never taken", $time);
    end
    req_valid <= 1'b0;  // one beat per request
    n = 0;
    do begin @(posedge sys_clk); n++; end while (rsp_valid !== 1'b1 && n < 50);
    if (rsp_valid !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: request never answered", $time);
    end
    r_lat = n;
    r_err = rsp_err;
    r_data = rsp_rdata;
  endtask : mem_acc

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    chk({mem_cen_n, mem_ce, mem_oen_n}, {4'hf, 4'h0, 4'hf}, "chip and output enables");
    chk({mem_wen_n, mem_qwen_n, mem_ben}, {1'b1, 4'hf, 4'h0}, "write and byte enables");
    chk({mem_adv_ld_n, mem_burst_order, mem_rnw, mem_cken, mem_cfg_entry}, 5'b11100, "burst ctl");
    chk({mem_dq_o, mem_dq_t}, 64'h0, "data out and tristate");
    chk({mem_par_o, mem_par_t}, 8'h0, "parity out");
    chk({mem_addr, mem_rst_pd_n}, {32'h0, 1'b1}, "address and power down");
    rst <= 1'b0;
    @(posedge sys_clk);
    $display("test reset levels done");
    for (int b = 0; b < 4; b++) begin
      reg_read(xmi_pkg::OFF_FAIL_ADDR_0 + 8'(4 * b));
      chk(rd, 32'h0, "fail addr reset");
      reg_read(xmi_pkg::OFF_ACCESS_CFG_0 + 8'(4 * b));
      chk(rd, 32'h24, "cfg reset");
    end
    reg_write(8'h14, 32'hffff_ffff);
    reg_read(8'h14);
    chk(rd, 32'hc000_0067, "cfg writable bits");
    for (int m = 0; m < 3; m++) begin
      reg_write(8'h18, 32'(m));
      reg_read(8'h18);
      chk(rd, 32'h24 | 32'(m), "cfg op mode");
    end
    reg_write(8'h14, 32'h0);
    reg_write(8'h18, 32'h0);
    reg_write(8'h00, 32'hffff_ffff);
    reg_read(8'h00);
    chk(rd, 32'h0, "fail addr read only");
    reg_read(8'h20);
    chk(rd, 32'h0, "unmapped read");
    $display("test registers done");
    mem_acc(1'b1, 2'h0, 32'h10, 32'h1122_3344, 4'hf);
    chk(r_lat, 2 + ACC, "write latency");
    chk(wen_cyc, ACC, "write strobe cycles");
    mem_acc(1'b0, 2'h0, 32'h10, 32'h0, 4'hf);
    chk({r_lat[7:0], r_err, r_data}, {8'(3 + ACC), 1'b0, 32'h1122_3344}, "read back");
    mem_acc(1'b1, 2'h0, 32'h10, 32'haabb_ccdd, 4'h5);
    chk({last_ben, last_qwen}, {4'h5, 4'ha}, "partial byte enables");
    mem_acc(1'b0, 2'h0, 32'h10, 32'h0, 4'hf);
    chk(r_data, 32'h11bb_33dd, "partial write merge");
    chk({cfg_cyc[15:0], cken_cyc[15:0], adv_cyc[15:0]}, 48'h0, "async bank strobes idle");
    $display("test data path done");
    corrupt <= 1'b1;
    mem_acc(1'b0, 2'h2, 32'h0000_0410, 32'h0, 4'hf);
    chk(r_err, 1'b1, "parity error response");
    corrupt <= 1'b0;
    reg_read(8'h08);
    chk(rd, 32'h0000_0410, "fail addr bank 2");
    reg_read(8'h00);
    chk(rd, 32'h0, "fail addr bank 0 untouched");
    mem_acc(1'b0, 2'h2, 32'h0000_0410, 32'h0, 4'hf);
    chk({r_err, r_data}, {1'b0, 32'h11bb_33dd}, "clean read");
    $display("test parity done");
    reg_write(8'h1c, 32'h0000_0040);
    mem_acc(1'b1, 2'h3, 32'h20, 32'h0, 4'hf);
    chk(cfg_cyc != 0, 1'b1, "cfg entry on write");
    rd = 32'(cfg_cyc);
    mem_acc(1'b0, 2'h3, 32'h20, 32'h0, 4'hf);
    chk(cfg_cyc, rd, "cfg entry quiet on read");
    reg_write(8'h14, 32'h4000_0000);
    mem_acc(1'b1, 2'h1, 32'h30, 32'h5, 4'hf);
    chk({cken_cyc != 0, adv_cyc}, {1'b1, 32'h1}, "sync bank strobes");
    chk(bad, 0, "pin turnaround and complements");
    $display("test sync and cfg entry done");
    test_done();
  end
endmodule : tb_top

/* File: verif/xmi_mem_model.sv */
// Purpose: behavioural external memory on the pin side of xmi_pin_if
// Assumes: one array shared by all banks, word index from address bits 5:2
// Notes:   released data lines show the inverse of the last word read
`timescale 1ns/10ps
module xmi_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [3:0]  cen_n,
  input  wire logic [3:0]  oen_n,
  input  wire logic        wen_n,
  input  wire logic [3:0]  qwen_n,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] dq_o,
  input  wire logic [3:0]  par_o,
  input  wire logic        corrupt,
  output logic      [31:0] dq_i,
  output logic      [3:0]  par_i
);
  logic [31:0] mem [16];
  logic [3:0]  pmem [16];
  logic [31:0] last_q = 32'h5a5a_0ff0;
  logic [3:0]  last_p = 4'h5;
  logic        rd_on;

  assign rd_on = (cen_n != 4'hf) && (oen_n != 4'hf);

  // stored parity is returned as written, so only a commanded fault flips it
  always @(posedge sys_clk) begin
    if ((cen_n != 4'hf) && !wen_n) begin
      for (int i = 0; i < 4; i++) begin
        if (!qwen_n[i]) begin
          mem[addr[5:2]][8*i +: 8] <= dq_o[8*i +: 8];
          pmem[addr[5:2]][i] <= par_o[i];
        end
      end
    end
    if (rd_on) begin
      last_q <= dq_i;
      last_p <= par_i;
    end
  end

  // data returned combinationally from the addressed word, not registered on sys_clk
  always_comb begin
    dq_i = rd_on ? mem[addr[5:2]] : ~last_q;
    par_i = rd_on ? (pmem[addr[5:2]] ^ {3'h0, corrupt}) : ~last_p;
  end
endmodule : xmi_mem_model
